// *** rtl/ssmt_byte_store.v ***
// Four-byte register store with registered read data.
// Assumes a single mclk domain and one writer port plus one frame-load port.
`include "ssmt_consts.vh"
module ssmt_byte_store (
  // Clock and reset
  input  wire        mclk,
  input  wire        arst_n,
  // Byte write port
  input  wire        wr_en,
  input  wire [1:0]  wr_addr,
  input  wire [7:0]  wr_data,
  // Whole-word load port
  input  wire        ld_en,
  input  wire [31:0] ld_data,
  // Read port
  input  wire [1:0]  rd_addr,
  output reg  [7:0]  rd_data,
  output wire [31:0] all_data
);
  reg [7:0] mem_reg [0:3];
  integer i;
  assign all_data = {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]};
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_reg[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (ld_en) begin
        mem_reg[0] <= ld_data[7:0];
        mem_reg[1] <= ld_data[15:8];
        mem_reg[2] <= ld_data[23:16];
        mem_reg[3] <= ld_data[31:24];
      end else if (wr_en) begin
        mem_reg[wr_addr] <= wr_data;
      end
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule // ssmt_byte_store

// *** rtl/ssmt_serial_unit.v ***
// Multibyte synchronous serial unit: 16/32-bit frames, MSB first, mode 0.
// Assumes host logic on mclk drives the control ports; the link is a master
// clock derived from mclk. No link clock enters this block.
//
// Behaviour
// - Length 2 runs 32-bit frames, four bytes
// - Length 1 runs 16-bit frames, bytes 0-1
// - Writing transmit bytes clears empty flag
// - 32-bit: byte 3 loaded sets empty flag
// - 16-bit: byte 1 loaded sets empty flag
// - Empty at last bit sets end flag
// - Receive frame to byte registers, set full
// - Reading receive bytes 0 and 1 clears full
`include "ssmt_consts.vh"
module ssmt_serial_unit (
  // Clock and reset
  input  wire       mclk,
  input  wire       arst_n,
  // Configuration
  input  wire [1:0] frame_length_field,
  input  wire       transmit_enable_bit,
  input  wire       receive_enable_bit,
  input  wire [7:0] clk_div,
  // Transmit byte registers
  input  wire       tx_wr,
  input  wire [1:0] tx_addr,
  input  wire [7:0] tx_data,
  // Receive byte registers
  input  wire       rx_rd,
  input  wire [1:0] rx_addr,
  output wire [7:0] rx_data,
  // Flags
  output reg        tx_buffer_empty_flag,
  output reg        tx_end_flag,
  input  wire       tx_end_clr,
  output reg        rx_full_flag,
  output reg        overrun_error_flag,
  input  wire       overrun_clr,
  output wire       bit_period_tick,
  // Serial link
  output reg        sck_out,
  output reg        sdo_out,
  input  wire       sdi_in,
  output reg        cs_n_out
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE  = 3'b100;

  reg  [2:0]  state_reg;
  reg  [31:0] shift_reg;
  reg  [5:0]  bits_reg;
  reg  [7:0]  div_reg;
  reg         sdi_s1_reg;
  reg         sdi_s2_reg;
  reg  [1:0]  loaded_len_reg;
  reg         rx_on_reg;
  reg  [1:0]  rd_seen_reg;
  wire        load_go;
  wire        half_tick;
  wire [31:0] tx_all;
  wire [5:0]  frame_bits;
  wire        rx_ld;
  wire [31:0] rx_word;

  function [5:0] len_bits;
    input [1:0] len;
    begin
      len_bits = (len == `SSMT_LEN_32) ? `SSMT_BITS_32 : `SSMT_BITS_16;
    end
  endfunction

  // Two-stage synchroniser on the serial input
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      sdi_s1_reg <= sdi_in;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  ssmt_byte_store u_tx_store (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .wr_en    (tx_wr),
    .wr_addr  (tx_addr),
    .wr_data  (tx_data),
    .ld_en    (1'b0),
    .ld_data  (32'h00000000),
    .rd_addr  (2'h0),
    .rd_data  (),
    .all_data (tx_all)
  );

  // 16-bit frames land in bytes 0-1, 32-bit in bytes 0-3
  // First received byte lands in byte 0 in both frame lengths
  assign rx_word = (loaded_len_reg == `SSMT_LEN_32) ?
                   {shift_reg[7:0], shift_reg[15:8], shift_reg[23:16], shift_reg[31:24]} :
                   {16'h0000, shift_reg[7:0], shift_reg[15:8]};
  assign rx_ld = (state_reg == ST_DONE) && rx_on_reg;

  ssmt_byte_store u_rx_store (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .wr_en    (1'b0),
    .wr_addr  (2'h0),
    .wr_data  (8'h00),
    .ld_en    (rx_ld),
    .ld_data  (rx_word),
    .rd_addr  (rx_addr),
    .rd_data  (rx_data),
    .all_data ()
  );

  assign frame_bits = len_bits(frame_length_field);
  // Transmission starts once transmit is enabled and the buffer holds fresh data
  assign load_go = (state_reg == ST_IDLE) && transmit_enable_bit && !tx_buffer_empty_flag;
  assign half_tick = (div_reg == 8'h00);
  assign bit_period_tick = half_tick && sck_out;

  // Serial clock divider: half period is clk_div+1 mclk cycles, or 5 when clk_div is 0
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 8'h00;
    end else if (state_reg != ST_SHIFT || half_tick) begin
      div_reg <= (clk_div == 8'h00) ? `SSMT_DIV_DEFAULT : clk_div;
    end else begin
      div_reg <= div_reg - 8'h01;
    end
  end

  // Frame engine
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ST_IDLE;
      shift_reg      <= 32'h00000000;
      bits_reg       <= 6'h00;
      sck_out        <= `SSMT_IDLE_LEVEL;
      sdo_out        <= 1'b0;
      cs_n_out       <= 1'b1;
      loaded_len_reg <= `SSMT_LEN_16;
      rx_on_reg      <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sck_out <= `SSMT_IDLE_LEVEL;
          if (load_go) begin
            if (frame_length_field == `SSMT_LEN_32) begin
              shift_reg <= {tx_all[7:0], tx_all[15:8], tx_all[23:16], tx_all[31:24]};
              sdo_out   <= tx_all[7];
            end else begin
              shift_reg <= {tx_all[7:0], tx_all[15:8], 16'h0000};
              sdo_out   <= tx_all[7];
            end
            bits_reg       <= frame_bits;
            loaded_len_reg <= frame_length_field;
            rx_on_reg      <= receive_enable_bit;
            cs_n_out       <= 1'b0;
            state_reg      <= ST_SHIFT;
          end else begin
            cs_n_out <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (half_tick) begin
            sck_out <= ~sck_out;
            if (!sck_out) begin
              shift_reg <= {shift_reg[30:0], sdi_s2_reg};
            end else begin
              sdo_out  <= shift_reg[31];
              bits_reg <= bits_reg - 6'h01;
              if (bits_reg == 6'h01) begin
                state_reg <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          if (loaded_len_reg != `SSMT_LEN_32) begin
            shift_reg <= {16'h0000, shift_reg[15:0]};
          end
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Transmit flags
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_end_flag          <= 1'b0;
    end else begin
      if (load_go) begin
        tx_buffer_empty_flag <= 1'b1;
      end else if (tx_wr) begin
        tx_buffer_empty_flag <= 1'b0;
      end
      if (state_reg == ST_DONE && tx_buffer_empty_flag) begin
        tx_end_flag <= 1'b1;
      end else if (tx_end_clr || tx_wr) begin
        tx_end_flag <= 1'b0;
      end
    end
  end

  // Receive flags: full clears after bytes 0 and 1 are both read
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_full_flag       <= 1'b0;
      overrun_error_flag <= 1'b0;
      rd_seen_reg        <= 2'b00;
    end else begin
      if (rx_ld) begin
        rx_full_flag <= 1'b1;
        rd_seen_reg  <= 2'b00;
      end else if (rx_rd && rx_addr[1] == 1'b0) begin
        rd_seen_reg[rx_addr[0]] <= 1'b1;
        if (rd_seen_reg[~rx_addr[0]]) begin
          rx_full_flag <= 1'b0;
        end
      end
      if (rx_ld && rx_full_flag) begin
        overrun_error_flag <= 1'b1;
      end else if (overrun_clr) begin
        overrun_error_flag <= 1'b0;
      end
    end
  end
endmodule // ssmt_serial_unit

// *** shared/ssmt_consts.vh ***
// Constants for the multibyte synchronous serial unit.
// Assumes a 10 MHz mclk; included by bare name from rtl files.
`ifndef SSMT_CONSTS_VH
`define SSMT_CONSTS_VH
`define SSMT_LEN_16        2'h1
`define SSMT_LEN_32        2'h2
`define SSMT_BYTES_16      3'h2
`define SSMT_BYTES_32      3'h4
`define SSMT_BITS_16       6'h10
`define SSMT_BITS_32       6'h20
`define SSMT_DIV_DEFAULT   8'h04
`define SSMT_IDLE_LEVEL    1'b0
`endif

// *** tb/ssmt_eeprom_model.sv ***
// Serial memory stand-in: captures the sent frame and answers with a given word.
// Assumes mode 0 framing, MSB first, select low for the whole frame.
module ssmt_eeprom_model (
  // Link
  input  wire logic        sck_out, sdo_out, cs_n_out, len32,
  // Answer and capture
  input  wire logic [31:0] reply,
  output logic             sdi_in,
  output logic [31:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh;
  initial sdi_in = 1'b0;
  always @(negedge cs_n_out) begin
    sh = len32 ? reply : {reply[15:0], 16'h0000};
    sdi_in = sh[31];
    got = 32'h0000_0000;
  end
  always @(posedge sck_out) if (!cs_n_out) got = {got[30:0], sdo_out};
  always @(negedge sck_out) if (!cs_n_out) begin
    sh = sh << 1;
    sdi_in = sh[31];
  end
  // Released line shows the inverse of its last level
  always @(posedge cs_n_out) sdi_in = ~sdi_in;
endmodule // ssmt_eeprom_model

// *** tb/ssmt_unit_sva.sv ***
// Port checker for the multibyte serial unit.
// Assumes clk_div stays fixed while frames run; bound to the unit below.
`include "ssmt_consts.vh"
module ssmt_unit_chk (
  // Clock and reset
  input wire logic       mclk, arst_n,
  // Control
  input wire logic [1:0] frame_length_field, rx_addr,
  input wire logic       receive_enable_bit, tx_wr, transmit_enable_bit, rx_rd,
  input wire logic [7:0] clk_div,
  // Flags and link
  input wire logic       tx_buffer_empty_flag, tx_end_flag, rx_full_flag, sck_out, cs_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [7:0] hi_cnt;
  logic [5:0] rise_cnt;
  logic       sck_d;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt   <= 8'h00;
      rise_cnt <= 6'h00;
      sck_d    <= 1'b0;
    end else begin
      hi_cnt   <= sck_out ? hi_cnt + 8'h01 : 8'h00;
      rise_cnt <= cs_n_out ? 6'h00 : rise_cnt + {5'h00, sck_out & ~sck_d};
      sck_d    <= sck_out;
    end
  end
  wr_clears_empty_a: assert property (tx_wr && !transmit_enable_bit |=> !tx_buffer_empty_flag)
    else $error("empty flag kept after write");
  start_empty_a: assert property ($fell(cs_n_out) |-> tx_buffer_empty_flag)
    else $error("empty flag low at frame start");
  frame_bits_a: assert property ($rose(cs_n_out) |-> rise_cnt ==
    (frame_length_field == `SSMT_LEN_32 ? `SSMT_BITS_32 : `SSMT_BITS_16)) else $error("bad bit count");
  end_needs_empty_a: assert property ($rose(tx_end_flag) |-> tx_buffer_empty_flag)
    else $error("end flag set while data waits");
  end_at_close_a: assert property ($rose(cs_n_out) && $past(tx_buffer_empty_flag)
    |-> $past(tx_end_flag)) else $error("end flag missing at frame close");
  full_at_close_a: assert property ($rose(cs_n_out) && receive_enable_bit |-> $past(rx_full_flag))
    else $error("full flag missing after receive");
  read_clears_full_a: assert property ((rx_rd && rx_addr == 2'h1) ##1 (rx_rd && rx_addr == 2'h0)
    |=> !rx_full_flag) else $error("full flag kept after reads");
  sck_half_a: assert property ($fell(sck_out) |-> hi_cnt ==
    (clk_div == 8'h00 ? 8'h05 : clk_div + 8'h01)) else $error("serial clock half period wrong");
  sck_idle_a: assert property (cs_n_out |-> !sck_out) else $error("serial clock moves outside frame");
  cover property ($rose(cs_n_out) && frame_length_field == `SSMT_LEN_32);
  cover property ($rose(cs_n_out) && receive_enable_bit);
  cover property ($fell(rx_full_flag));
endmodule // ssmt_unit_chk
bind ssmt_serial_unit ssmt_unit_chk chk_u (.mclk, .arst_n, .frame_length_field, .rx_addr,
  .receive_enable_bit, .tx_wr, .transmit_enable_bit, .rx_rd, .clk_div, .tx_buffer_empty_flag,
  .tx_end_flag, .rx_full_flag, .sck_out, .cs_n_out);

// *** tb/tb_ssmt_serial_unit.sv ***
// Self-checking bench: data write then status polls through the memory model.
// Assumes the checker binds itself; clk_div 3 gives an 800 ns serial clock.
`include "ssmt_consts.vh"
module tb_ssmt_serial_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, transmit_enable_bit, receive_enable_bit, tx_wr, rx_rd, len32;
  logic        tx_end_clr, overrun_clr, sdi_in, tx_buffer_empty_flag, tx_end_flag;
  logic        rx_full_flag, overrun_error_flag, bit_period_tick, sck_out, sdo_out, cs_n_out;
  logic [1:0]  frame_length_field, tx_addr, rx_addr;
  logic [7:0]  tx_data, rx_data, st;
  // Memory command codes; values are arbitrary for the stand-in model
  localparam logic [7:0] CMD_LATCH  = 8'h06;
  localparam logic [7:0] CMD_WRITE  = 8'h02;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  logic [31:0] reply, got, seed;
  int          mismatches, cmp_count;
  assign len32 = (frame_length_field == `SSMT_LEN_32);
  ssmt_serial_unit dut_u (.mclk, .arst_n, .frame_length_field, .transmit_enable_bit,
    .receive_enable_bit, .clk_div(8'h03), .tx_wr, .tx_addr, .tx_data, .rx_rd, .rx_addr, .rx_data,
    .tx_buffer_empty_flag, .tx_end_flag, .tx_end_clr, .rx_full_flag, .overrun_error_flag,
    .overrun_clr, .bit_period_tick, .sck_out, .sdo_out, .sdi_in, .cs_n_out);
  ssmt_eeprom_model mem_u (.sck_out, .sdo_out, .cs_n_out, .len32, .reply, .sdi_in, .got);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] act);
    cmp_count++;
    if (act !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One whole frame: load with transmit off, enable, wait for the end flag
  task automatic run(int n, logic [31:0] w, logic re);
    int t;
    frame_length_field = (n == 4) ? `SSMT_LEN_32 : `SSMT_LEN_16;
    receive_enable_bit = re;
    chk("empty_idle", 1, tx_buffer_empty_flag);
    tx_wr = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_addr = i[1:0];
      tx_data = w[31 - 8 * i -: 8];
      tick();
    end
    tx_wr = 1'b0;
    chk("empty_loaded", 0, tx_buffer_empty_flag);
    transmit_enable_bit = 1'b1;
    tick(2);
    chk("empty_moved", 1, tx_buffer_empty_flag);
    t = 0;
    while (tx_end_flag !== 1'b1 && t < 2000) begin
      tick();
      t++;
    end
    chk("frame_bits", (n == 4) ? w : {16'h0000, w[31:16]}, got);
    chk("end_set", 1, tx_end_flag);
    tx_end_clr = 1'b1;
    tick();
    tx_end_clr = 1'b0;
    tick();
    chk("end_clear", 0, tx_end_flag);
    tick(8);
    transmit_enable_bit = 1'b0;
  endtask
  // Read receive bytes 1 then 0, keep byte 1 in st
  task automatic read_pair();
    rx_addr = 2'h1;
    rx_rd = 1'b1;
    tick();
    st = rx_data;
    chk("rx_byte1", reply[7:0], rx_data);
    rx_addr = 2'h0;
    overrun_clr = 1'b1;
    tick();
    {rx_rd, overrun_clr} = 2'h0;
    chk("rx_byte0", reply[15:8], rx_data);
    tick();
    chk("full_clear", 0, {rx_full_flag, overrun_error_flag});
  endtask
  initial begin
    {arst_n, transmit_enable_bit, receive_enable_bit, tx_wr, rx_rd} = 5'h00;
    {tx_end_clr, overrun_clr, tx_addr, rx_addr, tx_data} = 14'h0000;
    frame_length_field = `SSMT_LEN_16;
    reply = 32'h0000_0000;
    seed = 32'h8506;
    mismatches = 0;
    cmp_count = 0;
    tick(3);
    arst_n = 1'b1;
    tick();
    chk("reset_flags", 5'h11, {tx_buffer_empty_flag, tx_end_flag, rx_full_flag,
      overrun_error_flag, cs_n_out});
    run(2, {CMD_LATCH, 24'h000000}, 1'b0);
    reply = 32'h0000_0002;
    run(2, {CMD_STATUS, 24'h000000}, 1'b1);
    chk("latch_full", 1, rx_full_flag);
    read_pair();
    chk("latch_bit", 1, st[1]);
    seed = lfsr(seed);
    run(4, {CMD_WRITE, seed[23:0]}, 1'b0);
    chk("no_receive", 0, rx_full_flag);
    for (int p = 0; p < 3; p++) begin
      seed = lfsr(seed);
      reply = {16'h0000, seed[15:1], p != 2};
      run(2, {CMD_STATUS, seed[31:24], 16'h0000}, 1'b1);
      chk("full_set", 1, rx_full_flag);
      chk("overrun", p == 1, overrun_error_flag);
      if (p != 0) begin
        read_pair();
        chk("busy_bit", p != 2, st[0]);
      end
    end
    receive_enable_bit = 1'b0;
    report_and_stop();
  end
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule // tb_ssmt_serial_unit
